// *** hdl/dpsac_consts.svh ***
`ifndef DPSAC_CONSTS_SVH
`define DPSAC_CONSTS_SVH
// ==========================================
// timing
`define DPSAC_CLK_MHZ 125
`define DPSAC_DEC_MHZ 16
`define DPSAC_HALF_TICKS 8
`define DPSAC_MID_MIN 12
`define DPSAC_LONG_MIN 20
`define DPSAC_IDLE_TICKS 48
`define DPSAC_SYNC_LATE 36
`define DPSAC_PRE_HALVES 32
`define DPSAC_SYNC_HALVES 8
`define DPSAC_HPD_IRQ_US 750
// ==========================================
// line coding and reply codes
`define DPSAC_ONE_LEVEL 1'b0
`define DPSAC_ACK 8'h00
`define DPSAC_I2C_NACK 8'h40
`define DPSAC_EDID_DEV 7'h50
`define DPSAC_REQ_BYTES 20
// ==========================================
// link parameter byte indices
`define DPSAC_IX_RATE 6'h10
`define DPSAC_IX_LANES 6'h11
`define DPSAC_IX_PATT 6'h12
`define DPSAC_IX_STAT0 6'h22
`define DPSAC_IX_STAT1 6'h23
`define DPSAC_IX_STAT2 6'h24
`endif

// *** hdl/dpsac_pkg.sv ***
package dpsac_pkg;
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} dpsac_txw_t;
	typedef struct packed {
		logic sop;
		logic eop;
		logic err;
		logic cha;
		logic [7:0] data;
	} dpsac_dbg_t;
	typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_PRE = 4'h2,
		RX_SYNC = 4'h4, RX_DATA = 4'h8} dpsac_rx_st_t;
	typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_PRE = 5'h02,
		TX_SYNC = 5'h04, TX_DATA = 5'h08, TX_STOP = 5'h10} dpsac_tx_st_t;
	typedef enum logic [6:0] {B_IDLE = 7'h01, B_WR = 7'h02,
		B_HDR = 7'h04, B_RD = 7'h08, B_MRD = 7'h10, B_MLAT = 7'h20,
		B_PUSH = 7'h40} dpsac_bld_st_t;
endpackage

// *** hdl/dpsac_aux_ctrl.sv ***
// Function
// (R1) the shared aux line is served by a data input, a data output and an output enable.
// (R2) incoming Manchester traffic is decoded by a state machine on a 16 MHz enable made by a phase accumulator from the 125 MHz clock.
// (R3) the aux state machine serves all link training requests, and identification requests only while the processor control option is off.
// (R4) a hot plug interrupt pulse is sent to the source when the main link reports signal loss.
// (R5) the connection input means a source is attached and the power input means it is powered.
// (R6) hot plug detect stays low while both connection and power inputs are low.
// (R7) every sent and received aux byte is copied onto a valid-qualified debug stream.
// (R8) identification memory reads and writes follow the aux transactions through the master port.
// (R9) the memory port uses an 8-bit byte address and separate 8-bit write and read data.
// (R10) memory read data is sampled exactly one cycle after the read is accepted.
// (R11) with the processor control option on, the memory port is left idle.
// (R12) the management controller is interrupted through a dedicated output.
// (R13) debug bytes carry start and end of packet flags and an error flag.
// (R14) the debug channel bit is 1 for a reply to the source and 0 for a request.
// (R15) a memory transfer is held while wait request is high.
// (R16) all logic runs on the one clock and returns to its start state under reset.
// (R17) the output enable is high only while a reply is transmitted.
`timescale 1ns/1ps
`include "dpsac_consts.svh"

// ==========================================
// fifo
module dpsac_fifo
	import dpsac_pkg::*;
#(
	parameter int W = 9,
	parameter int D = 4
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	logic [W-1:0] mem_q [0:D-1];
	logic [AW-1:0] wp_q, rp_q;
	logic [CW-1:0] cnt_q;
	logic wr, rd;
	assign in_ready = cnt_q != CW'(D);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (wr)
			mem_q[wp_q] <= in_data;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (wr)
				wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
			if (rd)
				rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
			if (wr && !rd)
				cnt_q <= cnt_q + CW'(1);
			else if (rd && !wr)
				cnt_q <= cnt_q - CW'(1);
		end
	end
endmodule

// ==========================================
// aux controller
module dpsac_aux_ctrl
	import dpsac_pkg::*;
#(
	parameter bit PROCESSOR_CONTROL_OPTION = 1'b0,
	parameter int IRQ_CYCLES = `DPSAC_HPD_IRQ_US * `DPSAC_CLK_MHZ,
	parameter int FIFO_DEPTH = 4
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic aux_in,
	output logic aux_out,
	output logic aux_oe,
	output logic hpd,
	input wire logic cable_detect,
	input wire logic pwr_detect,
	input wire logic link_lost,
	input wire logic [23:0] lane_status,
	output logic [4:0] lane_count,
	output logic [7:0] link_rate,
	output logic [1:0] train_pattern,
	output logic mgmt_irq,
	output logic [31:0] dbg_data,
	output logic dbg_valid,
	output logic dbg_sop,
	output logic dbg_eop,
	output logic dbg_err,
	output logic dbg_cha,
	output logic [7:0] mem_address,
	output logic mem_read,
	output logic mem_write,
	output logic [7:0] mem_writedata,
	input wire logic [7:0] mem_readdata,
	input wire logic mem_waitrequest
);
	localparam int HW = $clog2(IRQ_CYCLES + 1);

	function automatic logic [5:0] sat6(input logic [5:0] v);
		sat6 = (v == 6'h3F) ? v : v + 6'h01;
	endfunction

	function automatic logic [5:0] didx(input logic [19:0] a);
		didx = {a[9:8], a[3:0]};
	endfunction

	// ==========================================
	// 16 MHz enable
	logic [7:0] acc_q, acc_sum;
	logic tick_q;
	assign acc_sum = acc_q + 8'(`DPSAC_DEC_MHZ);
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc_q <= 8'h00;
			tick_q <= 1'b0;
		end
		else if (acc_sum >= 8'(`DPSAC_CLK_MHZ))
		begin
			acc_q <= acc_sum - 8'(`DPSAC_CLK_MHZ); // R2
			tick_q <= 1'b1;
		end
		else
		begin
			acc_q <= acc_sum;
			tick_q <= 1'b0;
		end
	end

	// ==========================================
	// manchester receiver
	dpsac_rx_st_t rx_st_q;
	dpsac_tx_st_t tx_st_q;
	logic smp_q, edge_w, rx_go, rx_byte_q, rx_end_q, rx_err_q;
	logic [5:0] iv_q, mid_q;
	logic [7:0] bsh_q;
	logic [2:0] bcnt_q;
	assign edge_w = tick_q && (aux_in != smp_q);
	assign rx_go = edge_w && rx_st_q == RX_SYNC
		&& iv_q >= 6'(`DPSAC_LONG_MIN);
	always_ff @(posedge clk)
	begin
		if (reset)
			smp_q <= 1'b0;
		else if (tick_q)
			smp_q <= aux_in;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			iv_q <= 6'h00;
		else if (tick_q)
			iv_q <= edge_w ? 6'h00 : sat6(iv_q);
	end
	always_ff @(posedge clk)
	begin
		rx_byte_q <= 1'b0;
		rx_end_q <= 1'b0;
		rx_err_q <= 1'b0;
		if (reset)
		begin
			rx_st_q <= RX_IDLE; // R16
			mid_q <= 6'h00;
			bsh_q <= 8'h00;
			bcnt_q <= 3'h0;
		end
		else if (tick_q)
		begin
			mid_q <= sat6(mid_q);
			case (rx_st_q)
				RX_IDLE:
					if (edge_w && tx_st_q == TX_IDLE)
						rx_st_q <= RX_PRE;
				RX_PRE:
					if (edge_w && iv_q >= 6'(`DPSAC_LONG_MIN))
						rx_st_q <= RX_SYNC;
					else if (iv_q >= 6'(`DPSAC_IDLE_TICKS))
						rx_st_q <= RX_IDLE;
				RX_SYNC:
					if (rx_go)
					begin
						rx_st_q <= RX_DATA;
						mid_q <= 6'(`DPSAC_HALF_TICKS);
						bcnt_q <= 3'h0;
						// late edge: mid edge of a leading zero bit
						if (iv_q >= 6'(`DPSAC_SYNC_LATE))
						begin
							mid_q <= 6'h00; // R2
							bsh_q <= {bsh_q[6:0], aux_in == `DPSAC_ONE_LEVEL};
							bcnt_q <= 3'h1;
						end
					end
					else if (edge_w || iv_q >= 6'(`DPSAC_IDLE_TICKS))
						rx_st_q <= RX_IDLE;
				RX_DATA:
					if (edge_w && iv_q >= 6'(`DPSAC_LONG_MIN))
					begin
						rx_st_q <= RX_IDLE;
						rx_end_q <= 1'b1;
						rx_err_q <= bcnt_q != 3'h0;
					end
					else if (edge_w && mid_q >= 6'(`DPSAC_MID_MIN))
					begin
						mid_q <= 6'h00; // R2
						bsh_q <= {bsh_q[6:0], aux_in == `DPSAC_ONE_LEVEL};
						bcnt_q <= bcnt_q + 3'h1;
						rx_byte_q <= bcnt_q == 3'h7;
					end
					else if (iv_q >= 6'(`DPSAC_IDLE_TICKS))
					begin
						rx_st_q <= RX_IDLE;
						rx_end_q <= 1'b1;
						rx_err_q <= 1'b1;
					end
				default:
					rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// ==========================================
	// request capture
	logic [7:0] req_q [0:`DPSAC_REQ_BYTES-1];
	logic [4:0] rx_n_q;
	always_ff @(posedge clk)
	begin
		if (reset)
			rx_n_q <= 5'h00;
		else if (rx_go)
			rx_n_q <= 5'h00;
		else if (rx_byte_q && rx_n_q < 5'(`DPSAC_REQ_BYTES))
		begin
			req_q[rx_n_q] <= bsh_q;
			rx_n_q <= rx_n_q + 5'h01;
		end
	end

	// ==========================================
	// reply builder and services
	dpsac_bld_st_t b_st_q;
	dpsac_txw_t fin_data, tx_w;
	logic [19:0] addr_w;
	logic [4:0] len_w, cnt_q, i_q;
	logic [5:0] ptr_q;
	logic [7:0] hdr_q, eoff_q, rdat_q, dp_rd;
	logic native_w, edid_ok, native_q, rd_q, fin_valid, fin_ready;
	logic [7:0] dpcd_q [0:63];
	assign addr_w = {req_q[0][3:0], req_q[1], req_q[2]};
	assign native_w = req_q[0][7];
	assign len_w = 5'(req_q[3][3:0]) + 5'h01;
	assign edid_ok = !native_w && !PROCESSOR_CONTROL_OPTION // R11
		&& addr_w[6:0] == `DPSAC_EDID_DEV;
	always_comb
	begin
		case (ptr_q)
			`DPSAC_IX_STAT0: dp_rd = lane_status[7:0]; // R3
			`DPSAC_IX_STAT1: dp_rd = lane_status[15:8];
			`DPSAC_IX_STAT2: dp_rd = lane_status[23:16];
			default: dp_rd = dpcd_q[ptr_q];
		endcase
	end
	assign mem_read = b_st_q == B_MRD; // R8
	assign mem_write = b_st_q == B_WR && !native_q && cnt_q != 5'h00
		&& i_q != 5'h04; // R8
	assign mem_address = eoff_q; // R9
	assign mem_writedata = req_q[i_q];
	assign fin_valid = b_st_q == B_HDR || b_st_q == B_PUSH
		|| (b_st_q == B_RD && native_q);
	always_comb
	begin
		fin_data = '{last: cnt_q == 5'h01, data: rdat_q};
		if (b_st_q == B_HDR)
			fin_data = '{last: !rd_q || cnt_q == 5'h00, data: hdr_q};
		else if (b_st_q == B_RD)
			fin_data.data = dp_rd;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			b_st_q <= B_IDLE;
			cnt_q <= 5'h00;
			i_q <= 5'h00;
			ptr_q <= 6'h00;
			hdr_q <= `DPSAC_ACK;
			eoff_q <= 8'h00;
			rdat_q <= 8'h00;
			native_q <= 1'b0;
			rd_q <= 1'b0;
		end
		else
			case (b_st_q)
				B_IDLE:
					if (rx_end_q && !rx_err_q && rx_n_q != 5'h00)
					begin // R3
						native_q <= native_w;
						rd_q <= req_q[0][4];
						ptr_q <= didx(addr_w);
						i_q <= 5'h04;
						hdr_q <= (native_w || edid_ok) ? `DPSAC_ACK
							: `DPSAC_I2C_NACK;
						b_st_q <= req_q[0][4] ? B_HDR : B_WR;
						if (!native_w && !edid_ok)
							cnt_q <= 5'h00;
						else if (req_q[0][4])
							cnt_q <= (rx_n_q >= 5'h04) ? len_w : 5'h00;
						else
							cnt_q <= (rx_n_q > 5'h04) ? rx_n_q - 5'h04 : 5'h00;
					end
				B_WR:
					if (cnt_q == 5'h00)
						b_st_q <= B_HDR;
					else if (native_q)
					begin
						ptr_q <= ptr_q + 6'h01;
						i_q <= i_q + 5'h01;
						cnt_q <= cnt_q - 5'h01;
					end
					else if (i_q == 5'h04)
					begin
						eoff_q <= req_q[4];
						i_q <= i_q + 5'h01;
						cnt_q <= cnt_q - 5'h01;
					end
					else if (!mem_waitrequest)
					begin // R15
						eoff_q <= eoff_q + 8'h01;
						i_q <= i_q + 5'h01;
						cnt_q <= cnt_q - 5'h01;
					end
				B_HDR:
					if (fin_ready)
						b_st_q <= fin_data.last ? B_IDLE : B_RD;
				B_RD:
					if (!native_q)
						b_st_q <= B_MRD;
					else if (fin_ready)
					begin
						ptr_q <= ptr_q + 6'h01;
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h01)
							b_st_q <= B_IDLE;
					end
				B_MRD:
					if (!mem_waitrequest)
						b_st_q <= B_MLAT; // R15
				B_MLAT:
				begin
					rdat_q <= mem_readdata; // R10
					eoff_q <= eoff_q + 8'h01;
					b_st_q <= B_PUSH;
				end
				B_PUSH:
					if (fin_ready)
					begin
						cnt_q <= cnt_q - 5'h01;
						b_st_q <= (cnt_q == 5'h01) ? B_IDLE : B_MRD;
					end
				default:
					b_st_q <= B_IDLE;
			endcase
	end

	// ==========================================
	// link parameters and management interrupt
	logic irq_q, lost_q, present;
	logic [HW-1:0] hcnt_q;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int k = 0; k < 64; k++)
				dpcd_q[k] <= 8'h00;
		end
		else if (b_st_q == B_WR && native_q && cnt_q != 5'h00)
			dpcd_q[ptr_q] <= req_q[i_q]; // R3
	end
	assign link_rate = dpcd_q[`DPSAC_IX_RATE];
	assign lane_count = dpcd_q[`DPSAC_IX_LANES][4:0];
	assign train_pattern = dpcd_q[`DPSAC_IX_PATT][1:0];
	always_ff @(posedge clk)
	begin
		if (reset)
			irq_q <= 1'b0;
		else
			irq_q <= (b_st_q == B_WR && native_q && cnt_q != 5'h00
				&& ptr_q[5:4] == 2'h1) || hcnt_q == HW'(IRQ_CYCLES); // R12
	end
	assign mgmt_irq = irq_q;

	// ==========================================
	// hot plug detect
	logic hpd_q;
	assign present = cable_detect || pwr_detect; // R5
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lost_q <= 1'b0;
			hcnt_q <= '0;
			hpd_q <= 1'b0;
		end
		else
		begin
			lost_q <= link_lost;
			if (link_lost && !lost_q && present)
				hcnt_q <= HW'(IRQ_CYCLES); // R4
			else if (hcnt_q != '0)
				hcnt_q <= hcnt_q - HW'(1);
			hpd_q <= present && hcnt_q == '0; // R6
		end
	end
	assign hpd = hpd_q;

	// ==========================================
	// reply fifo and manchester transmitter
	logic tx_v, tx_pop, out_q, oe_q, tlast_q, tx_first_q, half_end;
	logic [2:0] hc_q;
	logic [4:0] hn_q;
	logic [7:0] tsh_q;
	dpsac_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.in_data(fin_data),
		.out_valid(tx_v),
		.out_ready(tx_pop),
		.out_data(tx_w)
	);
	assign half_end = tick_q && hc_q == 3'(`DPSAC_HALF_TICKS - 1);
	assign tx_pop = half_end && tx_v && ((tx_st_q == TX_SYNC
		&& hn_q == 5'(`DPSAC_SYNC_HALVES - 1)) || (tx_st_q == TX_DATA
		&& hn_q == 5'h0F && !tlast_q));
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_st_q <= TX_IDLE;
			hc_q <= 3'h0;
			hn_q <= 5'h00;
			oe_q <= 1'b0;
			out_q <= 1'b0;
			tsh_q <= 8'h00;
			tlast_q <= 1'b0;
		end
		else if (tx_st_q == TX_IDLE)
		begin
			out_q <= 1'b0;
			if (tx_v && rx_st_q == RX_IDLE && !edge_w)
			begin
				tx_st_q <= TX_PRE;
				hc_q <= 3'h0;
				hn_q <= 5'h00;
				oe_q <= 1'b1; // R17
			end
		end
		else if (tick_q)
		begin
			hc_q <= hc_q + 3'h1;
			if (hc_q == 3'h0)
				case (tx_st_q)
					TX_PRE: out_q <= ~hn_q[0];
					TX_DATA: out_q <= tsh_q[~hn_q[3:1]] ^ hn_q[0];
					default: out_q <= hn_q < 5'h04;
				endcase
			if (half_end)
			begin
				hn_q <= hn_q + 5'h01;
				case (tx_st_q)
					TX_PRE:
						if (hn_q == 5'(`DPSAC_PRE_HALVES - 1))
						begin
							tx_st_q <= TX_SYNC;
							hn_q <= 5'h00;
						end
					TX_SYNC, TX_DATA:
						if (tx_pop)
						begin
							tx_st_q <= TX_DATA;
							hn_q <= 5'h00;
							tsh_q <= tx_w.data;
							tlast_q <= tx_w.last;
						end
						else if (tx_st_q == TX_SYNC ? hn_q == 5'h07
							: hn_q == 5'h0F)
						begin
							tx_st_q <= TX_STOP;
							hn_q <= 5'h00;
						end
					TX_STOP:
						if (hn_q == 5'(`DPSAC_SYNC_HALVES - 1))
						begin
							tx_st_q <= TX_IDLE;
							oe_q <= 1'b0; // R17
						end
					default:
						tx_st_q <= TX_IDLE;
				endcase
			end
		end
	end
	assign aux_out = out_q; // R1
	assign aux_oe = oe_q; // R1

	// ==========================================
	// debug stream
	dpsac_dbg_t pend_q, dbg_q;
	logic pend_v_q, rx_first_q, dbg_v_q;
	always_ff @(posedge clk)
	begin
		dbg_v_q <= 1'b0;
		if (reset)
		begin
			pend_q <= '0;
			dbg_q <= '0;
			pend_v_q <= 1'b0;
			rx_first_q <= 1'b0;
			tx_first_q <= 1'b0;
		end
		else
		begin
			if (rx_go)
				rx_first_q <= 1'b1;
			if (tx_st_q == TX_PRE)
				tx_first_q <= 1'b1;
			if (tx_pop)
			begin
				dbg_v_q <= 1'b1; // R7
				dbg_q <= '{sop: tx_first_q, eop: tx_w.last, err: 1'b0,
					cha: 1'b1, data: tx_w.data}; // R14
				tx_first_q <= 1'b0;
			end
			else if (rx_byte_q)
			begin
				dbg_v_q <= pend_v_q; // R7
				dbg_q <= pend_q;
				pend_q <= '{sop: rx_first_q, eop: 1'b0, err: 1'b0,
					cha: 1'b0, data: bsh_q}; // R14
				pend_v_q <= 1'b1;
				rx_first_q <= 1'b0;
			end
			else if (rx_end_q)
			begin
				dbg_v_q <= pend_v_q;
				dbg_q <= pend_q;
				dbg_q.eop <= 1'b1; // R13
				dbg_q.err <= rx_err_q; // R13
				pend_v_q <= 1'b0;
			end
		end
	end
	assign dbg_valid = dbg_v_q;
	assign dbg_data = {24'h000000, dbg_q.data};
	assign dbg_sop = dbg_q.sop;
	assign dbg_eop = dbg_q.eop;
	assign dbg_err = dbg_q.err;
	assign dbg_cha = dbg_q.cha;

	// ==========================================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_tick_rate: assert property (tick_q |=> (!tick_q)[*6] ##[1:2] tick_q) // R2
		else $error("decode enable spacing wrong");
	a_oe_rx_quiet: assert property (rx_st_q != RX_IDLE |-> !aux_oe) // R17
		else $error("driving line while receiving");
	a_hpd_gated: assert property (!present |=> !hpd) // R6
		else $error("hpd high without source");
	a_hpd_irq: assert property ($rose(link_lost) && present |-> ##[1:2] !hpd) // R4
		else $error("no hpd pulse on signal loss");
	a_mem_hold: assert property (mem_read && mem_waitrequest |=> mem_read && $stable(mem_address)) // R15
		else $error("read dropped under wait");
	a_mem_lat: assert property (mem_read && !mem_waitrequest |=> b_st_q == B_MLAT ##1 rdat_q == $past(mem_readdata)) // R10
		else $error("read data latency wrong");
	a_proc_off: assert property (PROCESSOR_CONTROL_OPTION |-> !mem_read && !mem_write) // R11
		else $error("memory port active under processor control");
	a_dbg_tx: assert property (tx_pop |=> dbg_valid && dbg_cha && aux_oe) // R14
		else $error("sent byte not mirrored");
	a_dbg_rx: assert property (rx_byte_q && pend_v_q && !tx_pop |=> dbg_valid && !dbg_cha && !dbg_eop) // R13
		else $error("received byte not mirrored");
	c_native_rd: cover property (b_st_q == B_RD && native_q && fin_ready);
	c_mem_rd: cover property (mem_read && !mem_waitrequest);
	c_hpd_irq: cover property ($fell(hpd) && present);
	c_full_fifo: cover property (fin_valid && !fin_ready);
endmodule

// *** dv/dpsac_src_model.sv ***
`timescale 1ns/1ps
// ==========
// upstream source on the aux line
module dpsac_src_model
(
	input wire logic clk,
	input wire logic aux_out,
	input wire logic aux_oe,
	output logic src_en,
	output logic src_lvl
);
	logic [7:0] rx_q[$];
	bit ph = 1'b0;
	initial
	begin
		src_en = 1'b0;
		src_lvl = 1'b0;
	end
	// one half bit, 62.5 clocks on average
	task automatic half(input logic v);
		src_lvl <= v;
		ph = ~ph;
		repeat (ph ? 62 : 63)
			@(posedge clk);
	endtask
	// preamble, sync, bytes msb first, stop; line released after
	task automatic send(input logic [7:0] b[$]);
		int i;
		while (aux_oe)
			@(posedge clk);
		src_en <= 1'b1;
		repeat (10)
		begin
			half(1'b0);
			half(1'b1);
		end
		repeat (4)
			half(1'b1);
		repeat (4)
			half(1'b0);
		foreach (b[k])
			for (i = 7; i >= 0; i--)
			begin
				half(b[k][i]);
				half(~b[k][i]);
			end
		repeat (4)
			half(1'b1);
		repeat (4)
			if (!aux_oe)
				half(1'b0);
		src_en <= 1'b0;
	endtask
	// collect reply bytes until the stop pattern
	task automatic recv(output int n);
		int t;
		int k;
		logic a;
		logic [7:0] sh;
		rx_q.delete();
		n = -1;
		t = 0;
		while (!aux_oe && t < 4000)
		begin
			@(posedge clk);
			t++;
		end
		if (!aux_oe)
			return;
		t = 0;
		while (t < 100)
		begin
			@(posedge clk);
			t = aux_out ? t + 1 : 0;
		end
		while (aux_out)
			@(posedge clk);
		repeat (250)
			@(posedge clk);
		for (k = 0; k < 160; k++)
		begin
			repeat (31)
				@(posedge clk);
			a = aux_out;
			repeat (63)
				@(posedge clk);
			if (a == aux_out)
				break;
			sh = {sh[6:0], a};
			if (k % 8 == 7)
				rx_q.push_back(sh);
			repeat (31)
				@(posedge clk);
		end
		n = rx_q.size();
		while (aux_oe)
			@(posedge clk);
	endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// ==========
// testbench
module testbench;
	localparam int IRQ_N = 20;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cable_detect = 1'b0;
	logic pwr_detect = 1'b0;
	logic link_lost = 1'b0;
	logic [23:0] lane_status = 24'hC3B2A1;
	logic [7:0] mem_readdata = 8'h00;
	logic slow = 1'b0;
	logic [1:0] wcnt = 2'h0;
	logic [7:0] mem [256];
	logic aux_out, aux_oe, hpd, mgmt_irq, src_en, src_lvl, aux_in;
	logic dbg_valid, dbg_sop, dbg_eop, dbg_err, dbg_cha;
	logic mem_read, mem_write, mem_waitrequest, opt_rd, opt_wr;
	logic [4:0] lane_count;
	logic [1:0] train_pattern;
	logic [7:0] link_rate, mem_address, mem_writedata;
	logic [31:0] dbg_data;
	logic held = 1'b0;
	logic [9:0] held_v;
	int err_total = 0;
	int samples_checked = 0;
	int n_req = 0, n_rep = 0, n_sop = 0, n_eop = 0, n_err = 0;
	int irq_cnt = 0, opt_hits = 0;
	logic [7:0] dq[$];

	always #4 clk = ~clk;
	// shared line, pulled low when nobody drives
	assign aux_in = aux_oe ? aux_out : src_en & src_lvl;
	assign mem_waitrequest = slow & (mem_read | mem_write) & (wcnt != 2'h2);

	dpsac_aux_ctrl #(.IRQ_CYCLES(IRQ_N)) i_dpsac_aux_ctrl (
		.clk(clk), .reset(reset), .aux_in(aux_in), .aux_out(aux_out),
		.aux_oe(aux_oe), .hpd(hpd), .cable_detect(cable_detect),
		.pwr_detect(pwr_detect), .link_lost(link_lost),
		.lane_status(lane_status), .lane_count(lane_count),
		.link_rate(link_rate), .train_pattern(train_pattern),
		.mgmt_irq(mgmt_irq), .dbg_data(dbg_data), .dbg_valid(dbg_valid),
		.dbg_sop(dbg_sop), .dbg_eop(dbg_eop), .dbg_err(dbg_err),
		.dbg_cha(dbg_cha), .mem_address(mem_address), .mem_read(mem_read),
		.mem_write(mem_write), .mem_writedata(mem_writedata),
		.mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest)
	);
	dpsac_aux_ctrl #(
		.PROCESSOR_CONTROL_OPTION(1'b1),
		.IRQ_CYCLES(IRQ_N)
	) i_dpsac_aux_ctrl_opt (
		.clk(clk), .reset(reset), .aux_in(aux_in), .aux_out(), .aux_oe(),
		.hpd(), .cable_detect(cable_detect), .pwr_detect(pwr_detect),
		.link_lost(link_lost), .lane_status(lane_status), .lane_count(),
		.link_rate(), .train_pattern(), .mgmt_irq(), .dbg_data(),
		.dbg_valid(), .dbg_sop(), .dbg_eop(), .dbg_err(), .dbg_cha(),
		.mem_address(), .mem_read(opt_rd), .mem_write(opt_wr),
		.mem_writedata(), .mem_readdata(mem_readdata),
		.mem_waitrequest(mem_waitrequest)
	);
	dpsac_src_model i_dpsac_src_model (
		.clk(clk), .aux_out(aux_out), .aux_oe(aux_oe),
		.src_en(src_en), .src_lvl(src_lvl)
	);

	// ==========
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========
	// identification memory, stalls when slow
	always @(posedge clk)
	begin
		wcnt <= mem_waitrequest ? wcnt + 2'h1 : 2'h0;
		mem_readdata <= ~mem_readdata;
		if (mem_write && !mem_waitrequest)
			mem[mem_address] <= mem_writedata;
		if (mem_read && !mem_waitrequest)
			mem_readdata <= mem[mem_address];
		if (held)
			check({mem_read, mem_write, mem_address}, held_v);
		held <= mem_waitrequest;
		held_v <= {mem_read, mem_write, mem_address};
	end
	// debug stream and interrupt monitor
	always @(posedge clk)
	begin
		irq_cnt += mgmt_irq;
		opt_hits += opt_rd | opt_wr;
		if (dbg_valid === 1'b1)
		begin
			if (dbg_cha)
				n_rep++;
			else
			begin
				n_req++;
				dq.push_back(dbg_data[7:0]);
			end
			n_sop += dbg_sop;
			n_eop += dbg_eop;
			n_err += dbg_err;
		end
	end

	// ==========
	// scenarios
	task automatic wt(input int n);
		repeat (n)
			@(posedge clk);
		#1;
	endtask
	task automatic xfer(input logic [7:0] req[$], input logic [7:0] exp[$]);
		int n;
		i_dpsac_src_model.send(req);
		i_dpsac_src_model.recv(n);
		check(n, exp.size());
		foreach (exp[k])
			check(i_dpsac_src_model.rx_q[k], exp[k]);
		wt(1);
		check(aux_oe, 1'b0);
	endtask
	task automatic t_reset;
		wt(11);
		check({hpd, aux_oe, mgmt_irq, dbg_valid, mem_read, mem_write}, 0);
		check({lane_count, link_rate}, 0);
		@(posedge clk);
		reset <= 1'b0;
		wt(3);
		check(hpd, 1'b0);
		for (int c = 1; c < 4; c++)
		begin
			@(posedge clk);
			{cable_detect, pwr_detect} <= c[1:0];
			wt(3);
			check(hpd, 1'b1);
		end
	endtask
	task automatic t_native;
		int r = n_req, p = n_rep, s = n_sop, e = n_eop, q = irq_cnt;
		xfer('{8'h80, 8'h01, 8'h00, 8'h02, 8'h0A, 8'h02, 8'h01},
			'{8'h00});
		check(link_rate, 8'h0A);
		check(lane_count, 5'h02);
		check(train_pattern, 2'h1);
		check(irq_cnt - q, 3);
		check(n_req - r, 7);
		check(n_rep - p, 1);
		check(n_sop - s, 2);
		check(n_eop - e, 2);
		check(n_err, 0);
		check(dq[$ - 6], 8'h80);
		check(dq[$], 8'h01);
		xfer('{8'h90, 8'h02, 8'h02, 8'h02},
			'{8'h00, 8'hA1, 8'hB2, 8'hC3});
	endtask
	task automatic t_i2c;
		@(posedge clk);
		slow <= 1'b1;
		xfer('{8'h00, 8'h00, 8'h50, 8'h02, 8'h10, 8'h5A, 8'h6B},
			'{8'h00});
		check(mem[8'h10], 8'h5A);
		check(mem[8'h11], 8'h6B);
		xfer('{8'h00, 8'h00, 8'h50, 8'h00, 8'h10}, '{8'h00});
		xfer('{8'h10, 8'h00, 8'h50, 8'h01},
			'{8'h00, 8'h5A, 8'h6B});
		xfer('{8'h10, 8'h00, 8'h37, 8'h00}, '{8'h40});
		check(opt_hits, 0);
	endtask
	task automatic t_hpd;
		int lo = 0;
		int q = irq_cnt;
		@(posedge clk);
		link_lost <= 1'b1;
		repeat (60)
		begin
			wt(1);
			lo += (hpd === 1'b0);
		end
		link_lost <= 1'b0;
		check(lo, IRQ_N);
		check(irq_cnt - q, 1);
	endtask

	initial
	begin
		t_reset;
		t_native;
		t_i2c;
		t_hpd;
		results;
	end
	// watchdog, about 100k clock cycles
	initial
	begin
		#800000;
		err_total++;
		results;
	end
endmodule
